// File: tbid_core.sv
// Purpose: execute the decoded subset, one instruction per four clocks
// Assumes: instruction word stable from the fetch strobe to the next
// Notes: the file is read every clock, phase 3 commits the result
`timescale 1ns/1ns
`include "tbid_defines.svh"
module tbid_core (
    input wire logic clock,
    input wire logic reset,
    input wire logic [11:0] insn_word,
    output logic [7:0] acc_out,
    output logic zero_flag,
    output logic cycle_end,
    output logic skip_taken,
    output logic jump_taken,
    output logic [8:0] jump_target,
    output logic file_wr_en,
    output logic [4:0] file_wr_addr,
    output logic [7:0] file_wr_data,
    output logic nop_exec
);
    import tbid_pkg::*;
    tbid_fields_t f;
    logic [7:0] file_rd;
    logic [1:0] phase_reg;
    logic [1:0] phase_next;
    tbid_state_t state_reg;
    tbid_state_t state_next;
    logic [7:0] acc_reg;
    logic [7:0] acc_next;
    logic zero_reg;
    logic zero_next;

    tbid_field_split u_split (
        .word(insn_word),
        .fields(f)
    );

    // reads every clock, so a write that lands at the end of phase 0 is seen by commit
    tbid_file_ram u_ram (
        .clock(clock),
        .rd_addr(f.file_addr),
        .rd_data(file_rd),
        .wr_en(file_wr_en),
        .wr_addr(file_wr_addr),
        .wr_data(file_wr_data)
    );

    wire commit = (phase_reg == `TBID_OSC_PER_CYCLE);
    wire flushing = (state_reg == TBID_FLUSH);
    wire tested_bit = file_rd[f.bit_sel];
    wire skip_now = !flushing && ((f.is_test_clr && !tested_bit) ||
        (f.is_test_set && tested_bit));
    wire [7:0] xor_lit = acc_reg ^ f.literal;
    wire [7:0] xor_file = acc_reg ^ file_rd;
    wire [7:0] set_val = file_rd | (8'h01 << f.bit_sel);
    wire xf = !flushing && f.is_xor_file;
    wire xl = !flushing && f.is_xor_lit;
    wire bs = !flushing && f.is_bit_set;
    wire to_file = xf && f.dest_file;
    wire wr_now = commit && (bs || to_file);
    wire [7:0] wr_val = bs ? set_val : xor_file;

    assign phase_next = phase_reg + 2'h1;
    // taken skip replaces the prefetched word with a no-op cycle
    always_comb begin
        case (state_reg)
            TBID_EXEC: begin
                if (commit && skip_now) begin
                    state_next = TBID_FLUSH;
                end else begin
                    state_next = TBID_EXEC;
                end
            end
            TBID_FLUSH: begin
                // the discarded word never starts a second flush
                if (commit) begin
                    state_next = TBID_EXEC;
                end else begin
                    state_next = TBID_FLUSH;
                end
            end
            default: begin
                state_next = TBID_EXEC;
            end
        endcase
    end
    // accumulator kept when result goes to the file
    assign acc_next = !commit ? acc_reg :
        xl ? xor_lit : (xf && !f.dest_file) ? xor_file :
        acc_reg;
    assign zero_next = !commit ? zero_reg :
        xl ? (xor_lit == 8'h00) : xf ? (xor_file == 8'h00) :
        zero_reg;

    always_ff @(posedge clock) begin
        if (reset) begin
            phase_reg <= 2'h0;
            state_reg <= TBID_EXEC;
            acc_reg <= `TBID_ACC_RESET;
            zero_reg <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            state_reg <= state_next;
            acc_reg <= acc_next;
            zero_reg <= zero_next;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            cycle_end <= 1'b0;
            skip_taken <= 1'b0;
            jump_taken <= 1'b0;
            jump_target <= 9'h000;
            file_wr_en <= 1'b0;
            file_wr_addr <= 5'h00;
            file_wr_data <= 8'h00;
            nop_exec <= 1'b0;
        end else begin
            cycle_end <= commit;
            skip_taken <= commit && skip_now;
            jump_taken <= commit && !flushing && f.is_jump;
            jump_target <= f.target;
            file_wr_en <= wr_now;
            file_wr_addr <= f.file_addr;
            file_wr_data <= wr_val;
            nop_exec <= commit && flushing;
        end
    end

    assign acc_out = acc_reg;
    assign zero_flag = zero_reg;

    property p_xor_lit;
        @(posedge clock) disable iff (reset)
        (commit && xl) |=> (acc_reg == ($past(acc_reg) ^ $past(f.literal)));
    endproperty
    a_xor_lit: assert property (p_xor_lit)
        else $error("literal xor result wrong");

    property p_xlw_no_write;
        @(posedge clock) disable iff (reset)
        (commit && xl) |=> !file_wr_en;
    endproperty
    a_xlw_no_write: assert property (p_xlw_no_write)
        else $error("literal xor wrote the file");

    // expected zero rebuilt from operands, not from the datapath wires
    property p_zero;
        @(posedge clock) disable iff (reset)
        (commit && (xl || xf)) |=> (zero_reg == (($past(acc_reg) ^
        ($past(xl) ? $past(f.literal) : $past(file_rd))) == 8'h00));
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero flag wrong");

    property p_acc_keep;
        @(posedge clock) disable iff (reset)
        (commit && to_file) |=> $stable(acc_reg);
    endproperty
    a_acc_keep: assert property (p_acc_keep)
        else $error("accumulator changed on file dest");

    property p_xwf_acc;
        @(posedge clock) disable iff (reset)
        (commit && xf && !f.dest_file) |=>
        (acc_reg == ($past(acc_reg) ^ $past(file_rd))) && !file_wr_en;
    endproperty
    a_xwf_acc: assert property (p_xwf_acc)
        else $error("file xor to accumulator wrong");

    property p_xwf_dest;
        @(posedge clock) disable iff (reset)
        (commit && to_file) |=> file_wr_en &&
        (file_wr_data == ($past(acc_reg) ^ $past(file_rd)));
    endproperty
    a_xwf_dest: assert property (p_xwf_dest)
        else $error("file xor write wrong");

    property p_wr_addr;
        @(posedge clock) disable iff (reset)
        (commit && (bs || to_file)) |=> (file_wr_addr == $past(f.file_addr));
    endproperty
    a_wr_addr: assert property (p_wr_addr)
        else $error("file write address wrong");

    property p_bset;
        @(posedge clock) disable iff (reset)
        (commit && bs) |=> file_wr_en && file_wr_data[$past(f.bit_sel)];
    endproperty
    a_bset: assert property (p_bset)
        else $error("bit set not written");

    property p_bset_flags;
        @(posedge clock) disable iff (reset)
        (commit && (bs || f.is_test_clr || f.is_test_set))
        |=> $stable(zero_reg);
    endproperty
    a_bset_flags: assert property (p_bset_flags)
        else $error("flag changed by bit op");

    property p_test_quiet;
        @(posedge clock) disable iff (reset)
        (commit && !flushing && (f.is_test_clr || f.is_test_set)) |=>
        !file_wr_en && $stable(acc_reg);
    endproperty
    a_test_quiet: assert property (p_test_quiet)
        else $error("bit test changed state");

    property p_skip_clr;
        @(posedge clock) disable iff (reset)
        (commit && !flushing && f.is_test_clr && !tested_bit) |=> skip_taken;
    endproperty
    a_skip_clr: assert property (p_skip_clr)
        else $error("clear bit did not skip");

    property p_skip_set;
        @(posedge clock) disable iff (reset)
        (commit && !flushing && f.is_test_set && tested_bit) |=> skip_taken;
    endproperty
    a_skip_set: assert property (p_skip_set)
        else $error("set bit did not skip");

    property p_no_skip;
        @(posedge clock) disable iff (reset)
        (commit && (flushing || !((f.is_test_clr && !tested_bit) ||
        (f.is_test_set && tested_bit)))) |=> !skip_taken;
    endproperty
    a_no_skip: assert property (p_no_skip)
        else $error("skip without a true test");

    property p_skip_nop;
        @(posedge clock) disable iff (reset)
        (commit && skip_now) |=> ##3 (commit && flushing);
    endproperty
    a_skip_nop: assert property (p_skip_nop)
        else $error("skip not followed by no-op");

    // the flush must last exactly one instruction cycle
    property p_flush_len;
        @(posedge clock) disable iff (reset)
        (commit && skip_now) |=> flushing [*4] ##1 !flushing;
    endproperty
    a_flush_len: assert property (p_flush_len)
        else $error("flush not one cycle long");

    property p_no_write_flush;
        @(posedge clock) disable iff (reset)
        (commit && flushing) |=> !file_wr_en && !jump_taken;
    endproperty
    a_no_write_flush: assert property (p_no_write_flush)
        else $error("discarded word had effect");

    property p_flush_quiet;
        @(posedge clock) disable iff (reset)
        (commit && flushing) |=> nop_exec && !skip_taken &&
        $stable(acc_reg) && $stable(zero_reg);
    endproperty
    a_flush_quiet: assert property (p_flush_quiet)
        else $error("discarded word changed state");

    property p_jump;
        @(posedge clock) disable iff (reset)
        (commit && !flushing && f.is_jump) |=> jump_taken &&
        (jump_target == $past(f.target));
    endproperty
    a_jump: assert property (p_jump)
        else $error("jump target wrong");

    property p_jump_quiet;
        @(posedge clock) disable iff (reset)
        (commit && !flushing && f.is_jump) |=> !file_wr_en &&
        $stable(acc_reg) && $stable(zero_reg);
    endproperty
    a_jump_quiet: assert property (p_jump_quiet)
        else $error("jump changed data state");

    property p_period;
        @(posedge clock) disable iff (reset)
        commit |=> !commit [*3] ##1 commit;
    endproperty
    a_period: assert property (p_period)
        else $error("cycle not four clocks");

    property p_end_pulse;
        @(posedge clock) disable iff (reset)
        1'b1 |=> (cycle_end == $past(commit));
    endproperty
    a_end_pulse: assert property (p_end_pulse)
        else $error("cycle end not one clock after commit");

    // every result pulse belongs to the end of an instruction cycle
    property p_pulse_gate;
        @(posedge clock) disable iff (reset)
        (skip_taken || jump_taken || file_wr_en || nop_exec) |-> cycle_end;
    endproperty
    a_pulse_gate: assert property (p_pulse_gate)
        else $error("result pulse outside cycle end");

    property p_hold;
        @(posedge clock) disable iff (reset)
        !commit |=> $stable(acc_reg) && $stable(zero_reg);
    endproperty
    a_hold: assert property (p_hold)
        else $error("state changed between commits");

    c_skip: cover property (@(posedge clock) commit && skip_now);
    c_jump: cover property (@(posedge clock) commit && !flushing && f.is_jump);
    c_xwf: cover property (@(posedge clock) commit && to_file);
    c_nop: cover property (@(posedge clock) nop_exec);
    c_zero_set: cover property (@(posedge clock) cycle_end && zero_reg);
endmodule : tbid_core

// File: tbid_core_bench.sv
// Purpose: self-checking bench for the instruction decoder core
// Assumes: one instruction per four clocks, pulses follow the commit
// Notes: file store powers up unknown, so bit sets fill it first
`timescale 1ns/1ns
`include "tbid_defines.svh"
module tbid_core_bench;
    import tbid_pkg::*;
    typedef struct packed {
        logic wen;
        logic [4:0] wa;
        logic [7:0] wd;
        logic wdk;
        logic [7:0] acc;
        logic z;
        logic sk;
        logic nop;
        logic nopk;
        logic jmp;
        logic [8:0] tgt;
    } tbid_exp_t;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [11:0] insn_word = 12'h000;
    logic [7:0] acc_out, file_wr_data;
    logic [8:0] jump_target;
    logic [4:0] file_wr_addr;
    logic zero_flag, cycle_end, skip_taken, jump_taken, file_wr_en, nop_exec;
    logic [7:0] m_acc = 8'h00;
    logic m_z = 1'b0;
    logic m_skip = 1'b0;
    logic m_jmp = 1'b0;
    logic [7:0] fm [32];
    logic fk [32];
    tbid_exp_t q [$];
    tbid_exp_t me;
    int mismatches = 0;
    int n_tests = 0;
    int gap = -1;
    tbid_core DUT (.clock(clock), .reset(reset), .insn_word(insn_word),
        .acc_out(acc_out), .zero_flag(zero_flag), .cycle_end(cycle_end),
        .skip_taken(skip_taken), .jump_taken(jump_taken),
        .jump_target(jump_target), .file_wr_en(file_wr_en),
        .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data),
        .nop_exec(nop_exec));
    initial begin
        forever #25 clock = ~clock;
    end
    task automatic end_sim();
        $display("mismatches %0d, comparisons %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [8:0] ex,
                       input logic [8:0] got);
        n_tests++;
        if (got !== ex) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    // bench reference of the subset; a skipped word does nothing
    function automatic tbid_exp_t model(input logic [11:0] w);
        tbid_exp_t e;
        logic [7:0] r;
        logic [4:0] f;
        e = '0;
        f = w[4:0];
        e.nopk = !m_jmp;
        r = m_acc ^ fm[f];
        if (m_skip) begin
            e.nop = 1'b1;
            m_skip = 1'b0;
        end else if (w[11:8] == `TBID_OPC_BIT_SET) begin
            e = '{1'b1, f, fm[f] | (8'h01 << w[7:5]), fk[f], 8'h00,
                  1'b0, 1'b0, 1'b0, e.nopk, 1'b0, 9'h000};
            fm[f] = e.wd;
            fk[f] = 1'b1;
        end else if (w[11:9] == 3'h3) begin
            m_skip = (fm[f][w[7:5]] == w[8]);
            e.sk = m_skip;
        end else if (w[11:8] == `TBID_OPC_XLW) begin
            m_acc = m_acc ^ w[7:0];
            m_z = (m_acc == 8'h00);
        end else if (w[11:6] == `TBID_OPC_XWF) begin
            m_z = (r == 8'h00);
            if (w[5]) begin
                e.wen = 1'b1;
                e.wa = f;
                e.wd = r;
                e.wdk = 1'b1;
                fm[f] = r;
            end else begin
                m_acc = r;
            end
        end else if (w[11:9] == `TBID_OPC_JMP) begin
            e.jmp = 1'b1;
            e.tgt = w[8:0];
        end
        m_jmp = e.jmp;
        e.acc = m_acc;
        e.z = m_z;
        return e;
    endfunction : model
    task automatic exec(input logic [11:0] w);
        q.push_back(model(w));
        insn_word <= w;
        repeat (4) @(posedge clock);
    endtask : exec
    always @(posedge clock) begin
        if (gap >= 0) begin
            gap++;
        end
        if (!reset && cycle_end === 1'b1) begin
            if (gap >= 0) begin
                chk("cycle_len", 9'(4), 9'(gap));
            end
            gap = 0;
            if (q.size() == 0) begin
                chk("spare_end", 9'(0), 9'(1));
            end else begin
                me = q.pop_front();
                chk("acc_out", 9'(me.acc), 9'(acc_out));
                chk("zero_flag", 9'(me.z), 9'(zero_flag));
                chk("skip_taken", 9'(me.sk), 9'(skip_taken));
                chk("wr_en", 9'(me.wen), 9'(file_wr_en));
                chk("jump_taken", 9'(me.jmp), 9'(jump_taken));
                if (me.nopk) begin
                    chk("nop_exec", 9'(me.nop), 9'(nop_exec));
                end
                if (me.wen) begin
                    chk("wr_addr", 9'(me.wa), 9'(file_wr_addr));
                end
                if (me.wen && me.wdk) begin
                    chk("wr_data", 9'(me.wd), 9'(file_wr_data));
                end
                if (me.jmp) begin
                    chk("target", me.tgt, jump_target);
                end
            end
        end
    end
    initial begin
        #400000;
        mismatches++;
        end_sim();
    end
    initial begin
        logic [31:0] r;
        void'($urandom(44));
        for (int i = 0; i < 32; i++) begin
            fk[i] = 1'b0;
        end
        repeat (16) @(posedge clock);
        chk("acc_reset", 9'(`TBID_ACC_RESET), 9'(acc_out));
        chk("end_reset", 9'(0), 9'(cycle_end));
        reset <= 1'b0;
        for (int i = 0; i < 256; i++) begin
            exec({`TBID_OPC_BIT_SET, 8'(i)});
        end
        exec({`TBID_OPC_XLW, 8'h00});
        exec({`TBID_OPC_XLW, 8'hb5});
        exec({`TBID_OPC_XWF, 6'h23});
        exec({`TBID_OPC_XWF, 6'h03});
        exec({`TBID_OPC_BTC, 8'h43});
        exec({`TBID_OPC_XLW, 8'hff});
        exec({`TBID_OPC_BTS, 8'h23});
        exec({`TBID_OPC_BTS, 8'h23});
        exec({`TBID_OPC_JMP, 9'h1a5});
        exec(`TBID_NOP_WORD);
        for (int i = 0; i < 400; i++) begin
            r = $urandom;
            case (r[2:0])
                3'h0: exec({`TBID_OPC_BIT_SET, r[15:8]});
                3'h1: exec({`TBID_OPC_BTC, r[15:8]});
                3'h2: exec({`TBID_OPC_BTS, r[15:8]});
                3'h3: exec({`TBID_OPC_XLW, r[15:8]});
                3'h4: exec({`TBID_OPC_XWF, r[13:8]});
                3'h5: exec({`TBID_OPC_JMP, r[16:8]});
                default: exec(`TBID_NOP_WORD);
            endcase
        end
        // stop before the last word commits a second time
        repeat (2) @(posedge clock);
        chk("queue_left", 9'(0), 9'(q.size()));
        end_sim();
    end
endmodule : tbid_core_bench

// File: tbid_defines.svh
// Purpose: constants for the twelve-bit instruction decoder subset
// Assumes: 12-bit instruction words, 8-bit data path
// Notes: field positions, opcodes and timing counts
`ifndef TBID_DEFINES_SVH
`define TBID_DEFINES_SVH
`define TBID_OP6_MSB 11
`define TBID_OP6_LSB 6
`define TBID_DEST_BIT 5
`define TBID_FILE_MSB 4
`define TBID_FILE_LSB 0
`define TBID_BIT_MSB 7
`define TBID_BIT_LSB 5
`define TBID_OP4_MSB 11
`define TBID_OP4_LSB 8
`define TBID_LIT_MSB 7
`define TBID_LIT_LSB 0
`define TBID_OP3_MSB 11
`define TBID_OP3_LSB 9
`define TBID_TGT_MSB 8
`define TBID_TGT_LSB 0
`define TBID_OPC_BIT_SET 4'h5
`define TBID_OPC_BTC 4'h6
`define TBID_OPC_BTS 4'h7
`define TBID_OPC_XLW 4'hf
`define TBID_OPC_XWF 6'h06
`define TBID_OPC_JMP 3'h5
`define TBID_NOP_WORD 12'h000
`define TBID_OSC_PER_CYCLE 2'h3
`define TBID_ACC_RESET 8'h00
`endif

// File: tbid_field_split.sv
// Purpose: split an instruction word into its fields
// Assumes: word is stable during the cycle
// Notes: purely combinational
`timescale 1ns/1ns
`include "tbid_defines.svh"
module tbid_field_split (
    input wire logic [11:0] word,
    output tbid_pkg::tbid_fields_t fields
);
    import tbid_pkg::*;
    wire [5:0] op6 = word[`TBID_OP6_MSB:`TBID_OP6_LSB];
    wire [3:0] op4 = word[`TBID_OP4_MSB:`TBID_OP4_LSB];
    wire [2:0] op3 = word[`TBID_OP3_MSB:`TBID_OP3_LSB];
    assign fields.is_bit_set = (op4 == `TBID_OPC_BIT_SET);
    assign fields.is_test_clr = (op4 == `TBID_OPC_BTC);
    assign fields.is_test_set = (op4 == `TBID_OPC_BTS);
    assign fields.is_xor_lit = (op4 == `TBID_OPC_XLW);
    assign fields.is_xor_file = (op6 == `TBID_OPC_XWF);
    assign fields.is_jump = (op3 == `TBID_OPC_JMP);
    assign fields.dest_file = word[`TBID_DEST_BIT];
    assign fields.file_addr = word[`TBID_FILE_MSB:`TBID_FILE_LSB];
    assign fields.bit_sel = word[`TBID_BIT_MSB:`TBID_BIT_LSB];
    assign fields.literal = word[`TBID_LIT_MSB:`TBID_LIT_LSB];
    assign fields.target = word[`TBID_TGT_MSB:`TBID_TGT_LSB];
endmodule : tbid_field_split

// File: tbid_file_ram.sv
// Purpose: 32 x 8 file register store
// Assumes: one write port, one registered read
// Notes: read data lag the address by one clock
`timescale 1ns/1ns
module tbid_file_ram (
    input wire logic clock,
    input wire logic [4:0] rd_addr,
    output logic [7:0] rd_data,
    input wire logic wr_en,
    input wire logic [4:0] wr_addr,
    input wire logic [7:0] wr_data
);
    logic [7:0] mem_reg [0:31];
    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
        rd_data <= mem_reg[rd_addr];
    end
endmodule : tbid_file_ram

// File: tbid_pkg.sv
// Purpose: types for the twelve-bit instruction decoder subset
// Assumes: included constants header
// Notes: decoded fields travel as one packed struct
package tbid_pkg;
    typedef enum logic [1:0] {
        TBID_EXEC = 2'h0,
        TBID_FLUSH = 2'h1
    } tbid_state_t;

    typedef struct packed {
        logic is_bit_set;
        logic is_test_clr;
        logic is_test_set;
        logic is_xor_lit;
        logic is_xor_file;
        logic is_jump;
        logic dest_file;
        logic [4:0] file_addr;
        logic [2:0] bit_sel;
        logic [7:0] literal;
        logic [8:0] target;
    } tbid_fields_t;
endpackage : tbid_pkg
